// ==== seh_pkg.sv ====
// seh_pkg.sv: constants and types for the state effecter command handler
// Notes on behaviour
// - A sub-effecter whose operation is disabled never takes a new state from a state-setting request; it answers 0x04.
// - When enabled by software, a sub-effecter falls back to the default state on being disabled.
// - When enabled by software, the default state may also be requested even outside the range.
// - The 16-bit handle must match the programmed one, and 0x0000 and 0xFFFF never match.
// - The count byte must be 0x01 to 0x08 and selects sub-effecters 0 up to count minus one.
// - An enable entry is an operational-state byte followed by an event-enable byte.
// - The operational-state byte is enabled, disabled (2) or unavailable; other values are bad data.
// - The event-enable byte switches event generation on or off for that sub-effecter.
// - An event-enable byte of 0xFF leaves the event setting as it is.
// - Every request gets one completion code byte, 0x80 when the handle is not recognised.
// - A state entry carries the requested state for one sub-effecter.
// - A state value out of the effecter's range answers 0x81.
// - An illegal state value (zero) in a request-set entry answers 0x82.
// - A state entry is a change-request byte then a state byte; only request-set entries change.
package seh_pkg;
	localparam logic [7:0] CMD_ENABLES = 8'h01;
	localparam logic [7:0] CMD_STATES = 8'h02;
	localparam logic [7:0] CC_OK = 8'h00;
	localparam logic [7:0] CC_INV_DATA = 8'h02;
	localparam logic [7:0] CC_INV_LEN = 8'h03;
	localparam logic [7:0] CC_NOT_READY = 8'h04;
	localparam logic [7:0] CC_UNSUP_CMD = 8'h05;
	localparam logic [7:0] CC_BAD_ID = 8'h80;
	localparam logic [7:0] CC_BAD_VAL = 8'h81;
	localparam logic [7:0] CC_BAD_STATE = 8'h82;
	localparam logic [7:0] OPB_MAX = 8'h03;
	localparam logic [1:0] OP_EN_MAX = 2'h1;
	localparam logic [1:0] OP_DIS = 2'h2;
	localparam logic [7:0] EV_ON_BYTE = 8'h00;
	localparam logic [7:0] EV_OFF_BYTE = 8'h01;
	localparam logic [7:0] EV_KEEP_BYTE = 8'hff;
	localparam logic [1:0] EVA_KEEP = 2'h0;
	localparam logic [1:0] EVA_ON = 2'h1;
	localparam logic [1:0] EVA_OFF = 2'h2;
	localparam logic [7:0] SET_REQ = 8'h01;
	localparam logic [7:0] ST_ILLEGAL = 8'h00;
	localparam logic [15:0] HANDLE_RSV_LO = 16'h0000;
	localparam logic [15:0] HANDLE_RSV_HI = 16'hffff;
	localparam logic [7:0] CNT_MIN = 8'h01;
	localparam logic [7:0] CNT_MAX = 8'h08;
	localparam logic [1:0] IDX_CMD = 2'h0;
	localparam logic [1:0] IDX_HLO = 2'h1;
	localparam logic [1:0] IDX_HHI = 2'h2;
	localparam logic [1:0] IDX_CNT = 2'h3;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_HANDLE = 8'h04;
	localparam logic [7:0] OFS_LIMIT = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_OPST = 8'h10;
	localparam logic [7:0] OFS_EVEN = 8'h14;
	localparam logic [7:0] OFS_ST_LO = 8'h18;
	localparam logic [7:0] OFS_ST_HI = 8'h1c;
	localparam logic [1:0] RST_CTRL = 2'h0;
	localparam logic [15:0] RST_HANDLE = 16'h0001;
	localparam logic [7:0] RST_MAX = 8'h01;
	localparam logic [7:0] RST_DFLT = 8'h01;
	localparam logic [1:0] RST_OP = 2'h1;
	localparam logic [7:0] RST_ST = 8'h01;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [4:0] {
		S_HDR = 5'b00001,
		S_ENT = 5'b00010,
		S_DRAIN = 5'b00100,
		S_FIN = 5'b01000,
		S_RESP = 5'b10000
	} seh_state_e;
endpackage

// ==== seh_upd_if.sv ====
// seh_upd_if.sv: update, status and configuration bundle between handler parts
`timescale 1ns/1ps
interface seh_upd_if;
	logic commit;
	logic is_en;
	logic [7:0] sel;
	logic [7:0][1:0] opv;
	logic [7:0][1:0] evv;
	logic [7:0][7:0] stv;
	logic auto_dflt;
	logic dflt_req;
	logic [7:0] dflt;
	logic [7:0] max_state;
	logic [15:0] handle;
	logic [7:0] last_cc;
	logic [7:0][1:0] op_cur;
	logic [7:0] ev_cur;
	logic [7:0][7:0] st_cur;
	logic [7:0] evt;
	modport store (input commit, is_en, sel, opv, evv, stv, auto_dflt, dflt,
		output op_cur, ev_cur, st_cur, evt);
	modport regs (output auto_dflt, dflt_req, dflt, max_state, handle,
		input last_cc, op_cur, ev_cur, st_cur);
endinterface

// ==== seh_store.sv ====
// seh_store.sv: per sub-effecter operational, event and state storage
`timescale 1ns/1ps
module seh_store (
	input wire logic aclk,
	input wire logic aresetn,
	seh_upd_if.store u
);
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_sub
			logic [1:0] op, next_op;
			logic ev, next_ev;
			logic [7:0] st, next_st;
			logic evt, next_evt;
			// Apply a committed request; only selected entries move
			always_comb begin
				next_op = op;
				next_ev = ev;
				next_st = st;
				if (u.commit && u.sel[i]) begin
					if (u.is_en) begin
						next_op = u.opv[i];
						if (u.evv[i] == seh_pkg::EVA_ON) begin
							next_ev = 1'b1;
						end else if (u.evv[i] == seh_pkg::EVA_OFF) begin
							next_ev = 1'b0;
						end
						// Fall back only when software asked for it
						if (u.auto_dflt && u.opv[i] == seh_pkg::OP_DIS) begin
							next_st = u.dflt;
						end
					end else begin
						next_st = u.stv[i];
					end
				end
				next_evt = next_ev && (next_st != st);
			end
			// Storage registers
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					op <= seh_pkg::RST_OP;
					ev <= 1'b0;
					st <= seh_pkg::RST_ST;
					evt <= 1'b0;
				end else begin
					op <= next_op;
					ev <= next_ev;
					st <= next_st;
					evt <= next_evt;
				end
			end
			assign u.op_cur[i] = op;
			assign u.ev_cur[i] = ev;
			assign u.st_cur[i] = st;
			assign u.evt[i] = evt;
		end
	endgenerate
endmodule

// ==== seh_axil.sv ====
// seh_axil.sv: AXI4-Lite register slave for configuration and status
`timescale 1ns/1ps
module seh_axil (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axil_awaddr,
	input wire logic s_axil_awvalid,
	output logic s_axil_awready,
	input wire logic [31:0] s_axil_wdata,
	input wire logic [3:0] s_axil_wstrb,
	input wire logic s_axil_wvalid,
	output logic s_axil_wready,
	output logic [1:0] s_axil_bresp,
	output logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [7:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	output logic s_axil_arready,
	output logic [31:0] s_axil_rdata,
	output logic [1:0] s_axil_rresp,
	output logic s_axil_rvalid,
	input wire logic s_axil_rready,
	seh_upd_if.regs u
);
	logic aw_held, next_aw_held, w_held, next_w_held;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic [1:0] ctrl, next_ctrl;
	logic [15:0] handle, next_handle;
	logic [7:0] maxs, next_maxs, dflt, next_dflt;
	// Address and data may arrive in either order; write once both held
	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = s_axil_bvalid;
		next_bresp = s_axil_bresp;
		next_arready = s_axil_arready;
		next_rvalid = s_axil_rvalid;
		next_rdata = s_axil_rdata;
		next_rresp = s_axil_rresp;
		next_ctrl = ctrl;
		next_handle = handle;
		next_maxs = maxs;
		next_dflt = dflt;
		if (s_axil_awvalid && s_axil_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axil_awaddr;
		end
		if (s_axil_wvalid && s_axil_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axil_wdata;
			next_w_strb = s_axil_wstrb;
		end
		if (s_axil_bvalid && s_axil_bready) begin
			next_bvalid = 1'b0;
		end
		if (aw_held && w_held && !s_axil_bvalid) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = seh_pkg::RESP_OKAY;
			case (aw_addr)
				seh_pkg::OFS_CTRL: if (w_strb[0]) next_ctrl = w_data[1:0];
				seh_pkg::OFS_HANDLE: begin
					if (w_strb[0]) next_handle[7:0] = w_data[7:0];
					if (w_strb[1]) next_handle[15:8] = w_data[15:8];
				end
				seh_pkg::OFS_LIMIT: begin
					if (w_strb[0]) next_maxs = w_data[7:0];
					if (w_strb[1]) next_dflt = w_data[15:8];
				end
				// Status words are read only; writes are dropped quietly
				seh_pkg::OFS_STATUS, seh_pkg::OFS_OPST, seh_pkg::OFS_EVEN,
				seh_pkg::OFS_ST_LO, seh_pkg::OFS_ST_HI: next_bresp = seh_pkg::RESP_OKAY;
				default: next_bresp = seh_pkg::RESP_SLVERR;
			endcase
		end
		if (s_axil_rvalid && s_axil_rready) begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
		if (s_axil_arvalid && s_axil_arready) begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rresp = seh_pkg::RESP_OKAY;
			case (s_axil_araddr)
				seh_pkg::OFS_CTRL: next_rdata = 32'(ctrl);
				seh_pkg::OFS_HANDLE: next_rdata = 32'(handle);
				seh_pkg::OFS_LIMIT: next_rdata = 32'({dflt, maxs});
				seh_pkg::OFS_STATUS: next_rdata = 32'(u.last_cc);
				seh_pkg::OFS_OPST: next_rdata = 32'(u.op_cur);
				seh_pkg::OFS_EVEN: next_rdata = 32'(u.ev_cur);
				seh_pkg::OFS_ST_LO: next_rdata = u.st_cur[3:0];
				seh_pkg::OFS_ST_HI: next_rdata = u.st_cur[7:4];
				default: begin
					next_rdata = 32'h0000_0000;
					next_rresp = seh_pkg::RESP_SLVERR;
				end
			endcase
		end
		// One write in flight: hold both channels until the response leaves
		next_awready = !next_aw_held && !next_bvalid;
		next_wready = !next_w_held && !next_bvalid;
	end
	// Bus and register state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axil_awready <= 1'b1;
			s_axil_wready <= 1'b1;
			s_axil_bvalid <= 1'b0;
			s_axil_bresp <= seh_pkg::RESP_OKAY;
			s_axil_arready <= 1'b1;
			s_axil_rvalid <= 1'b0;
			s_axil_rdata <= 32'h0000_0000;
			s_axil_rresp <= seh_pkg::RESP_OKAY;
			ctrl <= seh_pkg::RST_CTRL;
			handle <= seh_pkg::RST_HANDLE;
			maxs <= seh_pkg::RST_MAX;
			dflt <= seh_pkg::RST_DFLT;
		end else begin
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held <= next_w_held;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axil_awready <= next_awready;
			s_axil_wready <= next_wready;
			s_axil_bvalid <= next_bvalid;
			s_axil_bresp <= next_bresp;
			s_axil_arready <= next_arready;
			s_axil_rvalid <= next_rvalid;
			s_axil_rdata <= next_rdata;
			s_axil_rresp <= next_rresp;
			ctrl <= next_ctrl;
			handle <= next_handle;
			maxs <= next_maxs;
			dflt <= next_dflt;
		end
	end
	assign u.auto_dflt = ctrl[0];
	assign u.dflt_req = ctrl[1];
	assign u.handle = handle;
	assign u.max_state = maxs;
	assign u.dflt = dflt;
endmodule

// ==== seh_cmd_handler.sv ====
// seh_cmd_handler.sv: request parser, completion answer and top of the handler
`timescale 1ns/1ps
module seh_cmd_handler (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axil_awaddr,
	input wire logic s_axil_awvalid,
	output logic s_axil_awready,
	input wire logic [31:0] s_axil_wdata,
	input wire logic [3:0] s_axil_wstrb,
	input wire logic s_axil_wvalid,
	output logic s_axil_wready,
	output logic [1:0] s_axil_bresp,
	output logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [7:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	output logic s_axil_arready,
	output logic [31:0] s_axil_rdata,
	output logic [1:0] s_axil_rresp,
	output logic s_axil_rvalid,
	input wire logic s_axil_rready,
	input wire logic req_valid,
	input wire logic [7:0] req_data,
	input wire logic req_last,
	output logic req_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_code,
	input wire logic rsp_ready,
	output logic [7:0] evt_flags
);
	seh_upd_if upd();
	seh_pkg::seh_state_e st, next_st;
	logic [1:0] idx, next_idx;
	logic [2:0] ent, next_ent;
	logic half, next_half;
	logic is_en, next_is_en;
	logic setf, next_setf;
	logic [7:0] hlo, next_hlo;
	logic [3:0] cnt, next_cnt;
	logic [7:0] err, next_err;
	logic [7:0] sel, next_sel;
	logic [7:0][1:0] opv, next_opv;
	logic [7:0][1:0] evv, next_evv;
	logic [7:0][7:0] stv, next_stv;
	logic commit, next_commit;
	logic next_req_ready, next_rsp_valid;
	logic [7:0] next_rsp_code;
	logic acc, cnt_ok, last_ent;
	logic [15:0] hid;

	// Register slave and sub-effecter storage
	seh_axil u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axil_awaddr(s_axil_awaddr),
		.s_axil_awvalid(s_axil_awvalid),
		.s_axil_awready(s_axil_awready),
		.s_axil_wdata(s_axil_wdata),
		.s_axil_wstrb(s_axil_wstrb),
		.s_axil_wvalid(s_axil_wvalid),
		.s_axil_wready(s_axil_wready),
		.s_axil_bresp(s_axil_bresp),
		.s_axil_bvalid(s_axil_bvalid),
		.s_axil_bready(s_axil_bready),
		.s_axil_araddr(s_axil_araddr),
		.s_axil_arvalid(s_axil_arvalid),
		.s_axil_arready(s_axil_arready),
		.s_axil_rdata(s_axil_rdata),
		.s_axil_rresp(s_axil_rresp),
		.s_axil_rvalid(s_axil_rvalid),
		.s_axil_rready(s_axil_rready),
		.u(upd)
	);
	seh_store u_store (
		.aclk(aclk),
		.aresetn(aresetn),
		.u(upd)
	);

	// Staged request goes out only as a whole, on a clean frame
	assign upd.commit = commit;
	assign upd.is_en = is_en;
	assign upd.sel = sel;
	assign upd.opv = opv;
	assign upd.evv = evv;
	assign upd.stv = stv;
	assign upd.last_cc = rsp_code;
	assign evt_flags = upd.evt;

	// Byte decode helpers
	assign acc = req_valid && req_ready;
	assign hid = {req_data, hlo};
	assign cnt_ok = req_data >= seh_pkg::CNT_MIN && req_data <= seh_pkg::CNT_MAX;
	assign last_ent = ({1'b0, ent} == cnt - 4'h1);

	// Frame parser; the first error found is the one answered
	always_comb begin
		next_st = st;
		next_idx = idx;
		next_ent = ent;
		next_half = half;
		next_is_en = is_en;
		next_setf = setf;
		next_hlo = hlo;
		next_cnt = cnt;
		next_err = err;
		next_sel = sel;
		next_opv = opv;
		next_evv = evv;
		next_stv = stv;
		next_commit = 1'b0;
		next_req_ready = req_ready;
		next_rsp_valid = rsp_valid;
		next_rsp_code = rsp_code;
		unique case (st)
			seh_pkg::S_HDR: begin
				if (acc) begin
					unique case (idx)
						seh_pkg::IDX_CMD: begin
							next_is_en = (req_data == seh_pkg::CMD_ENABLES);
							next_sel = 8'h00;
							next_err = seh_pkg::CC_OK;
							if (req_data != seh_pkg::CMD_ENABLES && req_data != seh_pkg::CMD_STATES) begin
								next_err = seh_pkg::CC_UNSUP_CMD;
							end
						end
						seh_pkg::IDX_HLO: next_hlo = req_data;
						seh_pkg::IDX_HHI: begin
							// Reserved handles never name an effecter
							if (err == seh_pkg::CC_OK && (hid != upd.handle
								|| hid == seh_pkg::HANDLE_RSV_LO || hid == seh_pkg::HANDLE_RSV_HI)) begin
								next_err = seh_pkg::CC_BAD_ID;
							end
						end
						seh_pkg::IDX_CNT: begin
							next_cnt = req_data[3:0];
							if (err == seh_pkg::CC_OK && !cnt_ok) begin
								next_err = seh_pkg::CC_INV_DATA;
							end
						end
					endcase
					next_idx = idx + 2'h1;
					next_ent = 3'h0;
					next_half = 1'b0;
					// A bad count cannot steer entry parsing, so skip to the end
					if (idx == seh_pkg::IDX_CNT) begin
						next_st = cnt_ok ? seh_pkg::S_ENT : seh_pkg::S_DRAIN;
					end
					if (req_last) begin
						next_st = seh_pkg::S_FIN;
						next_req_ready = 1'b0;
						if (next_err == seh_pkg::CC_OK) begin
							next_err = seh_pkg::CC_INV_LEN;
						end
					end
				end
			end
			seh_pkg::S_ENT: begin
				if (acc) begin
					if (!half) begin
						if (is_en) begin
							next_opv[ent] = req_data[1:0];
							if (req_data > seh_pkg::OPB_MAX && next_err == seh_pkg::CC_OK) begin
								next_err = seh_pkg::CC_INV_DATA;
							end
						end else begin
							next_setf = (req_data == seh_pkg::SET_REQ);
							if (req_data > seh_pkg::SET_REQ && next_err == seh_pkg::CC_OK) begin
								next_err = seh_pkg::CC_INV_DATA;
							end
						end
					end else begin
						next_sel[ent] = is_en || setf;
						if (is_en) begin
							if (req_data == seh_pkg::EV_ON_BYTE) begin
								next_evv[ent] = seh_pkg::EVA_ON;
							end else if (req_data == seh_pkg::EV_OFF_BYTE) begin
								next_evv[ent] = seh_pkg::EVA_OFF;
							end else begin
								next_evv[ent] = seh_pkg::EVA_KEEP;
								if (req_data != seh_pkg::EV_KEEP_BYTE && next_err == seh_pkg::CC_OK) begin
									next_err = seh_pkg::CC_INV_DATA;
								end
							end
						end else if (setf) begin
							next_stv[ent] = req_data;
							if (next_err == seh_pkg::CC_OK) begin
								if (req_data == seh_pkg::ST_ILLEGAL) begin
									next_err = seh_pkg::CC_BAD_STATE;
								end else if (req_data > upd.max_state
									&& !(upd.dflt_req && req_data == upd.dflt)) begin
									next_err = seh_pkg::CC_BAD_VAL;
								end else if (upd.op_cur[ent] > seh_pkg::OP_EN_MAX) begin
									next_err = seh_pkg::CC_NOT_READY;
								end
							end
						end
						next_ent = ent + 3'h1;
						if (last_ent) begin
							next_st = seh_pkg::S_DRAIN;
						end
					end
					next_half = !half;
					if (req_last) begin
						next_st = seh_pkg::S_FIN;
						next_req_ready = 1'b0;
						if (!(half && last_ent) && next_err == seh_pkg::CC_OK) begin
							next_err = seh_pkg::CC_INV_LEN;
						end
					end
				end
			end
			seh_pkg::S_DRAIN: begin
				// Everything here is surplus; swallow it up to the frame end
				if (acc) begin
					if (next_err == seh_pkg::CC_OK) begin
						next_err = seh_pkg::CC_INV_LEN;
					end
					if (req_last) begin
						next_st = seh_pkg::S_FIN;
						next_req_ready = 1'b0;
					end
				end
			end
			seh_pkg::S_FIN: begin
				next_commit = (err == seh_pkg::CC_OK);
				next_rsp_valid = 1'b1;
				next_rsp_code = err;
				next_st = seh_pkg::S_RESP;
			end
			seh_pkg::S_RESP: begin
				if (rsp_ready) begin
					next_rsp_valid = 1'b0;
					next_req_ready = 1'b1;
					next_idx = seh_pkg::IDX_CMD;
					next_st = seh_pkg::S_HDR;
				end
			end
		endcase
	end

	// Parser registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= seh_pkg::S_HDR;
			idx <= seh_pkg::IDX_CMD;
			ent <= 3'h0;
			half <= 1'b0;
			is_en <= 1'b0;
			setf <= 1'b0;
			hlo <= 8'h00;
			cnt <= 4'h0;
			err <= seh_pkg::CC_OK;
			sel <= 8'h00;
			opv <= 16'h0000;
			evv <= 16'h0000;
			stv <= 64'h0000_0000_0000_0000;
			commit <= 1'b0;
			req_ready <= 1'b1;
			rsp_valid <= 1'b0;
			rsp_code <= seh_pkg::CC_OK;
		end else begin
			st <= next_st;
			idx <= next_idx;
			ent <= next_ent;
			half <= next_half;
			is_en <= next_is_en;
			setf <= next_setf;
			hlo <= next_hlo;
			cnt <= next_cnt;
			err <= next_err;
			sel <= next_sel;
			opv <= next_opv;
			evv <= next_evv;
			stv <= next_stv;
			commit <= next_commit;
			req_ready <= next_req_ready;
			rsp_valid <= next_rsp_valid;
			rsp_code <= next_rsp_code;
		end
	end

	// Checks on the parser and the storage it drives
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_resp_after_fin: assert property (
		st == seh_pkg::S_FIN |=> rsp_valid && rsp_code == $past(err))
		else $error("no completion code after frame end");
	a_code_holds: assert property (
		rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_code))
		else $error("completion code dropped before taken");
	a_bad_handle: assert property (
		acc && st == seh_pkg::S_HDR && idx == seh_pkg::IDX_HHI && err == seh_pkg::CC_OK
		&& hid != upd.handle |=> err == seh_pkg::CC_BAD_ID)
		else $error("foreign handle not flagged");
	a_count_range: assert property (
		acc && st == seh_pkg::S_HDR && idx == seh_pkg::IDX_CNT && !cnt_ok
		|=> err != seh_pkg::CC_OK ##1 !commit)
		else $error("bad count accepted");
	a_commit_clean: assert property (
		commit |-> rsp_valid && rsp_code == seh_pkg::CC_OK)
		else $error("update committed with error answer");
	a_state_frozen: assert property (
		!commit |=> $stable(upd.st_cur))
		else $error("state moved without commit");
	a_disabled_hold: assert property (
		commit && !is_en && upd.op_cur[0] > seh_pkg::OP_EN_MAX
		|=> upd.st_cur[0] == $past(upd.st_cur[0]))
		else $error("disabled sub-effecter changed state");
	a_zero_state: assert property (
		acc && st == seh_pkg::S_ENT && half && !is_en && setf
		&& req_data == seh_pkg::ST_ILLEGAL && err == seh_pkg::CC_OK
		|=> err == seh_pkg::CC_BAD_STATE)
		else $error("illegal state not flagged");
	a_evt_keep: assert property (
		commit && is_en && sel[0] && evv[0] == seh_pkg::EVA_KEEP |=> $stable(upd.ev_cur[0]))
		else $error("event setting changed on keep");
	a_auto_default: assert property (
		commit && is_en && sel[0] && opv[0] == seh_pkg::OP_DIS && upd.auto_dflt
		|=> upd.st_cur[0] == $past(upd.dflt))
		else $error("no fall back to default");

	c_enable_ok: cover property (st == seh_pkg::S_FIN && is_en && err == seh_pkg::CC_OK);
	c_states_ok: cover property (st == seh_pkg::S_FIN && !is_en && err == seh_pkg::CC_OK);
	c_bad_handle: cover property (st == seh_pkg::S_FIN && err == seh_pkg::CC_BAD_ID);
endmodule

// ==== seh_req_model.sv ====
// Requester model feeding request frames and taking completion codes
`timescale 1ns/1ps
module seh_req_model (
	input wire logic aclk,
	output logic req_valid,
	output logic [7:0] req_data,
	output logic req_last,
	input wire logic req_ready,
	input wire logic rsp_valid,
	output logic rsp_ready
);
	logic slow = 1'b0;
	initial begin
		req_valid = 1'b0;
		req_data = 8'h00;
		req_last = 1'b0;
		rsp_ready = 1'b1;
	end
	// Each byte held until taken; data line inverted once released
	task automatic send(input logic [7:0] b[$]);
		foreach (b[i]) begin
			req_valid <= 1'b1;
			req_data <= b[i];
			req_last <= (i == b.size() - 1);
			do @(posedge aclk); while (!req_ready);
		end
		req_valid <= 1'b0;
		req_last <= 1'b0;
		req_data <= ~b[b.size() - 1];
	endtask
	// Slow mode stalls the answer every other cycle
	always @(posedge aclk) rsp_ready <= slow ? ~rsp_ready : 1'b1;
endmodule

// ==== seh_cmd_handler_tb.sv ====
// Self-checking bench for the state effecter command handler
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
	$display("wrong value at %0t got %h expected %h", $time, g, e); end end
module seh_cmd_handler_tb;
	localparam logic [15:0] H = 16'h1234;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdata;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid;
	logic req_valid, req_last, req_ready, rsp_valid, rsp_ready;
	logic [7:0] req_data, rsp_code, evt_flags;
	logic [7:0] evt_seen = 8'h00;
	logic [7:0] cq[$];
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	// Oldest notes are popped once into these before the compare
	logic [7:0] cc_exp;
	logic [1:0] b_exp;
	logic [33:0] r_exp;
	logic [7:0] st[8];
	logic [31:0] seed = 32'h0000_001f;
	int bad_count = 0, compares = 0, cyc = 0;
	always #12.5 aclk = ~aclk;
	seh_req_model req_u (.aclk(aclk), .req_valid(req_valid), .req_data(req_data),
		.req_last(req_last), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready));
	seh_cmd_handler dut_u (.aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr),
		.s_axil_awvalid(awvalid), .s_axil_awready(awready), .s_axil_wdata(wdata),
		.s_axil_wstrb(4'hf), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
		.s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
		.s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
		.s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
		.s_axil_rready(rready), .req_valid(req_valid), .req_data(req_data),
		.req_last(req_last), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_code(rsp_code), .rsp_ready(rsp_ready), .evt_flags(evt_flags));
	// Watcher: results matched against the oldest note; also cuts a hang short
	always @(posedge aclk) begin
		cyc++;
		// Storage is unknown until the first reset edge, so skip it then
		if (aresetn) evt_seen <= evt_seen | evt_flags;
		if (cyc == 20000) begin
			bad_count++;
			complete_run();
		end
		if (rsp_valid && rsp_ready) begin
			cc_exp = cq.pop_front();
			`CHK(rsp_code, cc_exp)
		end
		if (bvalid && bready) begin
			b_exp = bq.pop_front();
			`CHK(bresp, b_exp)
		end
		if (rvalid && rready) begin
			r_exp = rq.pop_front();
			`CHK({rresp, rdata}, r_exp)
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Write: address and data offered together, each released when taken
	// Ready lines stay high after a call, so back-to-back calls never toggle them
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
		bq.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
		rq.push_back({r, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
	endtask
	task automatic frame(input logic [7:0] c, input logic [15:0] h, input logic [7:0] n,
		input logic [7:0] e[$], input logic [7:0] cc);
		logic [7:0] b[$];
		b = {c, h[7:0], h[15:8], n, e};
		cq.push_back(cc);
		req_u.send(b);
		while (cq.size() != 0) @(posedge aclk);
	endtask
	task automatic complete_run();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		logic [7:0] e[$];
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd(seh_pkg::OFS_HANDLE, 32'h0000_0001);
		rd(seh_pkg::OFS_OPST, 32'h0000_5555);
		rd(8'h20, 32'h0000_0000, seh_pkg::RESP_SLVERR);
		wr(seh_pkg::OFS_HANDLE, {16'h0000, H});
		wr(seh_pkg::OFS_LIMIT, 32'h0000_0205);
		wr(seh_pkg::OFS_CTRL, 32'h0000_0001);
		wr(seh_pkg::OFS_ST_LO, 32'h0000_0000);
		wr(8'h24, 32'h0000_0000, seh_pkg::RESP_SLVERR);
		$display("test registers done");
		frame(seh_pkg::CMD_STATES, 16'h0000, 1, '{1, 3}, seh_pkg::CC_BAD_ID);
		frame(seh_pkg::CMD_STATES, 16'hffff, 1, '{1, 3}, seh_pkg::CC_BAD_ID);
		frame(seh_pkg::CMD_STATES, H, 0, '{1, 3}, seh_pkg::CC_INV_DATA);
		frame(seh_pkg::CMD_STATES, H, 9, '{1, 3}, seh_pkg::CC_INV_DATA);
		frame(seh_pkg::CMD_STATES, H, 1, '{1, 6}, seh_pkg::CC_BAD_VAL);
		frame(seh_pkg::CMD_STATES, H, 2, '{1, 3, 1, 0}, seh_pkg::CC_BAD_STATE);
		frame(seh_pkg::CMD_STATES, H, 2, '{1, 3}, seh_pkg::CC_INV_LEN);
		frame(8'h07, H, 1, '{1, 3}, seh_pkg::CC_UNSUP_CMD);
		frame(seh_pkg::CMD_ENABLES, H, 1, '{4, 0}, seh_pkg::CC_INV_DATA);
		frame(seh_pkg::CMD_ENABLES, H, 1, '{1, 7}, seh_pkg::CC_INV_DATA);
		frame(seh_pkg::CMD_STATES, H, 1, '{2, 3}, seh_pkg::CC_INV_DATA);
		rd(seh_pkg::OFS_ST_LO, 32'h0101_0101);
		$display("test refusals done");
		// Eight random legal states with a slow requester
		req_u.slow = 1'b1;
		for (int i = 0; i < 8; i++) begin
			st[i] = 8'(rnd() % 5 + 1);
			e.push_back(seh_pkg::SET_REQ);
			e.push_back(st[i]);
		end
		frame(seh_pkg::CMD_STATES, H, 8, e, seh_pkg::CC_OK);
		rd(seh_pkg::OFS_ST_HI, {st[7], st[6], st[5], st[4]});
		frame(seh_pkg::CMD_STATES, H, 2, '{1, 3, 0, 4}, seh_pkg::CC_OK);
		rd(seh_pkg::OFS_ST_LO, {st[3], st[2], st[1], 8'h03});
		req_u.slow = 1'b0;
		$display("test states done");
		frame(seh_pkg::CMD_ENABLES, H, 1, '{2, 0}, seh_pkg::CC_OK);
		rd(seh_pkg::OFS_OPST, 32'h0000_5556);
		rd(seh_pkg::OFS_ST_LO, {st[3], st[2], st[1], 8'h02});
		frame(seh_pkg::CMD_STATES, H, 1, '{1, 4}, seh_pkg::CC_NOT_READY);
		rd(seh_pkg::OFS_STATUS, 32'h0000_0004);
		frame(seh_pkg::CMD_ENABLES, H, 2, '{2, 255, 1, 1}, seh_pkg::CC_OK);
		rd(seh_pkg::OFS_EVEN, 32'h0000_0001);
		wr(seh_pkg::OFS_LIMIT, 32'h0000_0902);
		wr(seh_pkg::OFS_CTRL, 32'h0000_0003);
		frame(seh_pkg::CMD_STATES, H, 2, '{0, 0, 1, 9}, seh_pkg::CC_OK);
		rd(seh_pkg::OFS_ST_LO, {st[3], st[2], 8'h09, 8'h02});
		`CHK(evt_seen, 8'h01)
		$display("test enables done");
		complete_run();
	end
endmodule
